// file: cfg_hdr_pkg.sv
// Purpose: Constants for the bridge configuration header register slice
// Assumes: Dword-aligned configuration offsets, active-low byte enables
// Notes: Shared by the register bank and its users
package cfg_hdr_pkg;
   // ==========================================================
   // Offsets
   localparam logic [7:0] class_dword_off = 8'h08;
   localparam logic [7:0] line_dword_off = 8'h0C;
   localparam logic [7:0] busnum_dword_off = 8'h18;
   // ==========================================================
   // Fixed values
   localparam logic [7:0] prog_interface_val = 8'h00;
   localparam logic [7:0] subclass_val = 8'h04;
   localparam logic [7:0] base_class_val = 8'h06;
   localparam logic [7:0] header_layout_val = 8'h01;
   // ==========================================================
   // Reset values
   localparam logic [7:0] line_size_rst = 8'h00;
   localparam logic [7:0] master_timer_rst = 8'h00;
   localparam logic [7:0] bus_num_rst = 8'h00;
   // ==========================================================
   // Cache line clamp
   localparam logic [7:0] line_size_max = 8'h10;
   // ==========================================================
   // Field positions (low bit of each byte lane)
   localparam int lane0_lsb = 0;
   localparam int lane1_lsb = 8;
   localparam int lane2_lsb = 16;
   localparam int lane3_lsb = 24;
endpackage

// file: bridge_config_header_regs.sv
// Purpose: Class, cache line, latency timer and bus number header registers
// Assumes: Configuration decode done upstream; cfg_wr/cfg_rd are one-cycle strobes
// Notes: Read data is registered, valid one cycle after the read strobe
`timescale 1ns/100ps

module bridge_config_header_regs
(
   // Clock and reset
   input wire logic mclk,
   input wire logic srst,
   // Configuration access
   input wire logic cfg_wr,
   input wire logic cfg_rd,
   input wire logic [7:0] cfg_dword_addr,
   input wire logic [3:0] upstream_cmd_byte_en_n,
   input wire logic [31:0] cfg_wdata,
   output logic [31:0] cfg_rdata,
   output logic cfg_rvalid,
   // Primary master timing status
   input wire logic frame_start,
   input wire logic grant_lost,
   input wire logic first_data_done,
   input wire logic mwi_active,
   // Register values to bridge logic
   output logic [7:0] line_size_eff,
   output logic [7:0] upstream_master_timer,
   output logic timer_expired,
   output logic release_bus,
   output logic [7:0] upstream_bus_num,
   output logic [7:0] downstream_bus_num,
   output logic [7:0] highest_behind_bus_num
);
   import cfg_hdr_pkg::*;

   logic [7:0] line_size_dwords_q;
   logic [7:0] timer_count_q;
   logic timer_run_q;

   // ==========================================================
   // Helpers
   function automatic logic [7:0] clamp_line(input logic [7:0] v);
      if (v == 8'h00 || (v & (v - 8'h01)) != 8'h00 || v > line_size_max)
      begin
         // Zero kept as zero: no cache line programmed yet
         return (v == 8'h00) ? 8'h00 : line_size_max;
      end
      return v;
   endfunction

   function automatic logic lane_wr(input logic [7:0] off, input int lane);
      return cfg_wr && cfg_dword_addr == off && !upstream_cmd_byte_en_n[lane];
   endfunction

   // ==========================================================
   // Writable fields
   always_ff @(posedge mclk)
   begin
      if (srst)
      begin
         line_size_dwords_q <= line_size_rst;
      end
      else if (lane_wr(line_dword_off, 0))
      begin
         line_size_dwords_q <= cfg_wdata[lane0_lsb +: 8];
      end
   end

   always_ff @(posedge mclk)
   begin
      if (srst)
      begin
         line_size_eff <= line_size_rst;
      end
      else
      begin
         line_size_eff <= clamp_line(line_size_dwords_q);
      end
   end

   always_ff @(posedge mclk)
   begin
      if (srst)
      begin
         upstream_master_timer <= master_timer_rst;
      end
      else if (lane_wr(line_dword_off, 1))
      begin
         upstream_master_timer <= cfg_wdata[lane1_lsb +: 8];
      end
   end

   always_ff @(posedge mclk)
   begin
      if (srst)
      begin
         upstream_bus_num <= bus_num_rst;
         downstream_bus_num <= bus_num_rst;
         highest_behind_bus_num <= bus_num_rst;
      end
      else
      begin
         if (lane_wr(busnum_dword_off, 0))
         begin
            upstream_bus_num <= cfg_wdata[lane0_lsb +: 8];
         end
         if (lane_wr(busnum_dword_off, 1))
         begin
            downstream_bus_num <= cfg_wdata[lane1_lsb +: 8];
         end
         if (lane_wr(busnum_dword_off, 2))
         begin
            highest_behind_bus_num <= cfg_wdata[lane2_lsb +: 8];
         end
      end
   end

   // ==========================================================
   // Primary master latency timer
   // Counts down from frame start, one clock per step
   always_ff @(posedge mclk)
   begin
      if (srst)
      begin
         timer_count_q <= master_timer_rst;
         timer_run_q <= 1'b0;
      end
      else if (frame_start)
      begin
         timer_count_q <= upstream_master_timer;
         timer_run_q <= 1'b1;
      end
      else if (timer_run_q && timer_count_q != 8'h00)
      begin
         timer_count_q <= timer_count_q - 8'h01;
      end
   end

   always_ff @(posedge mclk)
   begin
      if (srst)
      begin
         timer_expired <= 1'b0;
         release_bus <= 1'b0;
      end
      else
      begin
         timer_expired <= timer_run_q && timer_count_q == 8'h00;
         // Zero timer: expired at once, so first data phase ends it
         release_bus <= timer_run_q && timer_count_q == 8'h00 && grant_lost
                        && first_data_done && !mwi_active;
      end
   end

   // ==========================================================
   // Read path
   always_ff @(posedge mclk)
   begin
      if (srst)
      begin
         cfg_rdata <= 32'h0000_0000;
         cfg_rvalid <= 1'b0;
      end
      else
      begin
         cfg_rvalid <= cfg_rd;
         if (cfg_rd)
         begin
            if (cfg_dword_addr == class_dword_off)
            begin
               // Low byte is revision, outside this block
               cfg_rdata <= {base_class_val, subclass_val, prog_interface_val,
                             8'h00};
            end
            else if (cfg_dword_addr == line_dword_off)
            begin
               cfg_rdata <= {8'h00, header_layout_val, upstream_master_timer,
                             line_size_dwords_q};
            end
            else if (cfg_dword_addr == busnum_dword_off)
            begin
               cfg_rdata <= {8'h00, highest_behind_bus_num, downstream_bus_num,
                             upstream_bus_num};
            end
            else
            begin
               cfg_rdata <= 32'h0000_0000;
            end
         end
      end
   end

   // ==========================================================
   // Checks
   chk_ro_class_fixed: assert property (@(posedge mclk) disable iff (srst)
      cfg_rd && cfg_dword_addr == class_dword_off |=> cfg_rdata[31:8] == 24'h060400)
      else $error("class bytes wrong");
   chk_header_type_fixed: assert property (@(posedge mclk) disable iff (srst)
      cfg_rd && cfg_dword_addr == line_dword_off |=> cfg_rdata[23:16] == 8'h01)
      else $error("header type wrong");
   chk_line_clamp_val: assert property (@(posedge mclk) disable iff (srst)
      line_size_dwords_q == 8'h05 || line_size_dwords_q > 8'h10 |=> line_size_eff == 8'h10)
      else $error("line size not clamped");
   chk_line_write_val: assert property (@(posedge mclk) disable iff (srst)
      lane_wr(line_dword_off, 0) |=> line_size_dwords_q == $past(cfg_wdata[7:0]))
      else $error("line size not written");
   chk_line_write_lane: assert property (@(posedge mclk) disable iff (srst)
      cfg_wr && cfg_dword_addr == line_dword_off && upstream_cmd_byte_en_n[0]
      |=> $stable(line_size_dwords_q))
      else $error("disabled lane written");
   chk_timer_write: assert property (@(posedge mclk) disable iff (srst)
      lane_wr(line_dword_off, 1) |=> upstream_master_timer == $past(cfg_wdata[15:8]))
      else $error("timer not written");
   chk_prim_bus_write: assert property (@(posedge mclk) disable iff (srst)
      lane_wr(busnum_dword_off, 0) |=> upstream_bus_num == $past(cfg_wdata[7:0]))
      else $error("primary bus not written");
   chk_sec_bus_write: assert property (@(posedge mclk) disable iff (srst)
      lane_wr(busnum_dword_off, 1) |=> downstream_bus_num == $past(cfg_wdata[15:8]))
      else $error("secondary bus not written");
   chk_sub_bus_write: assert property (@(posedge mclk) disable iff (srst)
      lane_wr(busnum_dword_off, 2) |=> highest_behind_bus_num == $past(cfg_wdata[23:16]))
      else $error("subordinate bus not written");
   chk_zero_timer_release: assert property (@(posedge mclk) disable iff (srst)
      release_bus |-> !$past(mwi_active) && $past(grant_lost))
      else $error("release without cause");
endmodule

// file: cfg_master_model.sv
// Purpose: Configuration master on the primary side of the header slice
// Assumes: One-cycle strobes, read answer one cycle after the read edge
// Notes: Signals change 1 ns after the rising edge
`timescale 1ns/100ps
module cfg_master_model
(
   // Clock
   input wire logic mclk,
   // Configuration access
   output logic cfg_wr,
   output logic cfg_rd,
   output logic [7:0] cfg_dword_addr,
   output logic [3:0] upstream_cmd_byte_en_n,
   output logic [31:0] cfg_wdata,
   input wire logic [31:0] cfg_rdata,
   input wire logic cfg_rvalid
);
   initial
   begin
      {cfg_wr, cfg_rd} = 2'h0;
      cfg_dword_addr = 8'h00;
      upstream_cmd_byte_en_n = 4'hF;
      cfg_wdata = 32'h0;
   end
   task automatic wr(input logic [7:0] a, input logic [3:0] be, input logic [31:0] d);
      @(posedge mclk) #1;
      {cfg_wr, cfg_dword_addr, upstream_cmd_byte_en_n, cfg_wdata} = {1'b1, a, be, d};
      @(posedge mclk) #1;
      cfg_wr = 1'b0;
      // Released data must not look valid
      cfg_wdata = ~d;
      cfg_dword_addr = ~a;
   endtask
   task automatic rd(input logic [7:0] a, output logic [31:0] d, output logic ok);
      ok = 1'b0;
      d = 32'h0;
      @(posedge mclk) #1;
      {cfg_rd, cfg_dword_addr, upstream_cmd_byte_en_n} = {1'b1, a, 4'h0};
      @(posedge mclk) #1;
      cfg_rd = 1'b0;
      cfg_dword_addr = ~a;
      for (int i = 0; i < 4 && !ok; i++)
      begin
         if (cfg_rvalid === 1'b1)
         begin
            ok = 1'b1;
            d = cfg_rdata;
         end
         else
            @(posedge mclk) #1;
      end
   endtask
endmodule

// file: tb_top.sv
// Purpose: Self-checking bench for the header register slice
// Assumes: Master model drives the access side
// Notes: Other inputs driven 1 ns after the edge
`timescale 1ns/100ps
module tb_top;
   logic mclk, srst, cfg_wr, cfg_rd, cfg_rvalid, timer_expired, release_bus;
   logic frame_start, grant_lost, first_data_done, mwi_active;
   logic [7:0] cfg_dword_addr, line_size_eff, upstream_master_timer;
   logic [7:0] upstream_bus_num, downstream_bus_num, highest_behind_bus_num;
   logic [3:0] upstream_cmd_byte_en_n;
   logic [31:0] cfg_wdata, cfg_rdata;
   int mismatches = 0;
   int check_count = 0;
   cfg_master_model i_cfg_master_model (
      .mclk(mclk),
      .cfg_wr(cfg_wr),
      .cfg_rd(cfg_rd),
      .cfg_dword_addr(cfg_dword_addr),
      .upstream_cmd_byte_en_n(upstream_cmd_byte_en_n),
      .cfg_wdata(cfg_wdata),
      .cfg_rdata(cfg_rdata),
      .cfg_rvalid(cfg_rvalid)
   );
   bridge_config_header_regs i_bridge_config_header_regs (
      .mclk(mclk),
      .srst(srst),
      .cfg_wr(cfg_wr),
      .cfg_rd(cfg_rd),
      .cfg_dword_addr(cfg_dword_addr),
      .upstream_cmd_byte_en_n(upstream_cmd_byte_en_n),
      .cfg_wdata(cfg_wdata),
      .cfg_rdata(cfg_rdata),
      .cfg_rvalid(cfg_rvalid),
      .frame_start(frame_start),
      .grant_lost(grant_lost),
      .first_data_done(first_data_done),
      .mwi_active(mwi_active),
      .line_size_eff(line_size_eff),
      .upstream_master_timer(upstream_master_timer),
      .timer_expired(timer_expired),
      .release_bus(release_bus),
      .upstream_bus_num(upstream_bus_num),
      .downstream_bus_num(downstream_bus_num),
      .highest_behind_bus_num(highest_behind_bus_num)
   );
   initial
   begin
      mclk = 1'b0;
      forever #2 mclk = ~mclk;
   end
   task automatic give_verdict;
      $display("checks %0d mismatches %0d", check_count, mismatches);
      if (mismatches == 0 && check_count > 0)
         $display("ALL CHECKS OK");
      else
         $display("CHECKS NOT OK");
      $finish;
   endtask
   task automatic check(input string n, input logic [31:0] e, input logic [31:0] g);
      check_count++;
      if (g !== e)
      begin
         mismatches++;
         $display("[ERR] %s expected %h seen %h", n, e, g);
      end
   endtask
   task automatic rd_check(input string n, input logic [7:0] a, input logic [31:0] e);
      logic [31:0] d;
      logic ok;
      i_cfg_master_model.rd(a, d, ok);
      check({n, " rvalid"}, 32'h1, {31'h0, ok});
      if (!ok)
         give_verdict();
      check(n, e, d);
   endtask
   task automatic test_reset;
      rd_check("class", 8'h08, 32'h06040000);
      rd_check("line", 8'h0C, 32'h00010000);
      rd_check("bus", 8'h18, 32'h00000000);
      check("line_eff", 32'h0, {24'h0, line_size_eff});
      $display("test_reset done");
   endtask
   task automatic test_lanes;
      i_cfg_master_model.wr(8'h08, 4'h0, 32'hFFFFFFFF);
      i_cfg_master_model.wr(8'h0C, 4'h3, 32'hFFFFFFFF);
      // Primary and subordinate set before any forwarding use
      i_cfg_master_model.wr(8'h18, 4'hA, 32'h44332211);
      check("busses", 32'h00330011, {8'h0, highest_behind_bus_num,
         downstream_bus_num, upstream_bus_num});
      i_cfg_master_model.wr(8'h18, 4'h5, 32'h44332211);
      // Unmapped dword: writes dropped, reads zero
      i_cfg_master_model.wr(8'h10, 4'h0, 32'hFFFFFFFF);
      rd_check("unmapped", 8'h10, 32'h00000000);
      rd_check("bus rd", 8'h18, 32'h00332211);
      rd_check("class ro", 8'h08, 32'h06040000);
      rd_check("line ro", 8'h0C, 32'h00010000);
      $display("test_lanes done");
   endtask
   task automatic test_line_size;
      logic [7:0] v[5] = '{8'h08, 8'h05, 8'h20, 8'h01, 8'h10};
      logic [7:0] e[5] = '{8'h08, 8'h10, 8'h10, 8'h01, 8'h10};
      for (int i = 0; i < 5; i++)
      begin
         i_cfg_master_model.wr(8'h0C, 4'hE, {24'h0, v[i]});
         repeat (2) @(posedge mclk);
         #1;
         check("line_eff", {24'h0, e[i]}, {24'h0, line_size_eff});
      end
      $display("test_line_size done");
   endtask
   task automatic test_timer;
      int n;
      i_cfg_master_model.wr(8'h0C, 4'hD, 32'h00000300);
      check("timer", 32'h3, {24'h0, upstream_master_timer});
      rd_check("timer rd", 8'h0C, 32'h00010310);
      // Value 3: count reaches zero three clocks after frame, flag one later
      @(posedge mclk) #1;
      frame_start = 1'b1;
      @(posedge mclk) #1;
      frame_start = 1'b0;
      repeat (3) @(posedge mclk);
      #1;
      check("expired early", 32'h0, {31'h0, timer_expired});
      @(posedge mclk) #1;
      check("expired", 32'h1, {31'h0, timer_expired});
      check("no grant loss", 32'h0, {31'h0, release_bus});
      i_cfg_master_model.wr(8'h0C, 4'hD, 32'h0);
      @(posedge mclk) #1;
      {frame_start, grant_lost, first_data_done} = 3'h7;
      @(posedge mclk) #1;
      frame_start = 1'b0;
      n = 0;
      while (release_bus !== 1'b1 && n < 8)
      begin
         @(posedge mclk) #1;
         n++;
      end
      check("release", 32'h1, {31'h0, release_bus});
      // Memory write and invalidate keeps the bus
      mwi_active = 1'b1;
      repeat (2) @(posedge mclk);
      #1;
      check("release mwi", 32'h0, {31'h0, release_bus});
      {grant_lost, first_data_done, mwi_active} = 3'h0;
      $display("test_timer done");
   endtask
   initial
   begin
      {srst, frame_start, grant_lost, first_data_done, mwi_active} = 5'h10;
      repeat (4) @(posedge mclk);
      #1;
      srst = 1'b0;
      test_reset();
      test_lanes();
      test_line_size();
      test_timer();
      give_verdict();
   end
endmodule
